// >>> pbs_pkg.sv
// Shared constants for the pipelined burst memory port.
// Assumes a single rising-edge clock and the top module importing this package.
package pbs_pkg;

  // ************************************************************
  // Organisation of the array
  // ************************************************************
  localparam int DATA_W_WIDE   = 36;      // Wide variant word width
  localparam int DATA_W_NARROW = 18;      // Narrow variant word width
  localparam int ADDR_W_WIDE   = 20;      // One million words
  localparam int ADDR_W_NARROW = 21;      // Two million words
  localparam int LANES_WIDE    = 4;       // Byte lanes in the wide variant
  localparam int LANES_NARROW  = 2;       // Byte lanes in the narrow variant

  // ************************************************************
  // Burst and pipeline
  // ************************************************************
  localparam int          BURST_LEN   = 4;     // Accesses per external address
  localparam int          CNT_W       = 2;     // Burst counter width
  localparam int          PIPE_STAGES = 2;     // Read pipeline depth
  localparam logic        ORDER_LIN   = 1'b0;  // Order select low picks linear
  localparam logic [1:0]  CNT_RESET   = 2'h0;  // Counter value at burst start
  localparam logic [1:0]  CNT_STEP    = 2'h1;  // Counter increment

  // ************************************************************
  // Sleep and buffering
  // ************************************************************
  localparam logic [1:0]  WAKE_CYCLES = 2'h2;  // Wake-up time after sleep ends
  localparam int          WFIFO_DEPTH = 16;    // Pending self-timed writes

endpackage

// >>> pbs_port.sv
// Synchronous interface logic of a pipelined burst static memory, with its array.
// Assumes all synchronous inputs are stable around the rising edge of mclk and
// that the master keeps the order select static and waits out the wake-up time.
//
// What this block does
// R1: Two-stage read pipeline, four-access bursts.
// R2: Two-bit counter loaded from address low bits.
// R3: Either address strobe starts a burst.
// R4: Later burst addresses generated internally, advance-gated.
// R5: Order select is a static level.
// R6: Global write writes every byte lane.
// R7: Else lane written when gate and lane low.
// R8: High primary select blocks processor strobe.
// R9: Sleep powers down regardless of clock.
// R10: Select after two cycles, deselect after one.
// R11: Output drive enable acts asynchronously.
// R12: Writes registered then completed self-timed.
// R13: Address and controls captured in registers.
// R14: Array of wide or narrow words.
// R15: Inputs sampled on rising edges, three exceptions.
// R16: Resume two cycles after sleep ends.
// R17: Advance ignored on processor strobe edge.
// R18: Read data to data-out then output buffer.
// R19: Linear increments, interleaved XORs count.
`timescale 1ns/1ps

// ************************************************************
// Write FIFO: holds registered writes until the array takes them
// ************************************************************
module pbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  import pbs_pkg::*;

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   cnt;
  } pbs_fifo_s;

  pbs_fifo_s       s;
  pbs_fifo_s       next_s;
  logic [WIDTH-1:0] store [DEPTH];
  logic            push;
  logic            pop;

  // Full and empty come straight from the stored count
  assign in_ready  = (s.cnt != (PW+1)'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data  = store[s.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and count update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wp = (s.wp == PW'(DEPTH-1)) ? '0 : s.wp + PW'(1);
    end
    if (pop) begin
      next_s.rp = (s.rp == PW'(DEPTH-1)) ? '0 : s.rp + PW'(1);
    end
    next_s.cnt = s.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Storage has no reset; contents are only read once written
  always_ff @(posedge mclk) begin
    if (push) begin
      store[s.wp] <= in_data;
    end
  end

endmodule

// ************************************************************
// Burst port and array
// ************************************************************
module pbs_port #(
  parameter int DATA_W = pbs_pkg::DATA_W_WIDE,
  parameter int ADDR_W = pbs_pkg::ADDR_W_WIDE,
  parameter int LANES  = pbs_pkg::LANES_WIDE,
  parameter int FIFO_D = pbs_pkg::WFIFO_DEPTH
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              processor_address_strobe_n,
  input  wire logic              controller_address_strobe_n,
  input  wire logic              burst_advance_n,
  input  wire logic              global_write_n,
  input  wire logic              byte_write_gate_n,
  input  wire logic [LANES-1:0]  lane_write_n,
  input  wire logic              primary_chip_select_n,
  input  wire logic              second_chip_select,
  input  wire logic              third_chip_select_n,
  input  wire logic              burst_order_select,
  input  wire logic              sleep_request,
  input  wire logic              output_enable_n,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe_n,
  output logic                   write_ready,
  output logic                   powered_down
);
  import pbs_pkg::*;

  localparam int LANE_W = DATA_W / LANES;
  localparam int WREC_W = ADDR_W + LANES + DATA_W;

  typedef struct packed {
    logic              active;   // Burst in progress
    logic [CNT_W-1:0]  base;     // Loaded low address bits
    logic [CNT_W-1:0]  cnt;      // Burst count
    logic [ADDR_W-3:0] hi;       // Registered high address bits
    logic              rd_p1;    // Read address registered
    logic [ADDR_W-1:0] rd_addr;
    logic              rd_p2;    // Data-out register loaded
    logic [DATA_W-1:0] dout;
    logic              drive;    // Output buffer holds valid data
    logic [DATA_W-1:0] obuf;
    logic [1:0]        wake;     // Wake-up cycles left
    logic              asleep;
    logic              wr_ready;
    logic              desel_q;  // Deselect seen on the last edge
  } pbs_state_s;

  pbs_state_s        s;
  pbs_state_s        next_s;
  logic [DATA_W-1:0] mem [2**ADDR_W];  // see R14
  logic [DATA_W-1:0] mem_rd;
  logic              asleep_now;
  logic              cs_on;
  logic              ps_start;
  logic              cs_start;
  logic              wr_any;
  logic              desel;
  logic [LANES-1:0]  lane_mask;
  logic [CNT_W-1:0]  low_cur;
  logic [CNT_W-1:0]  low_next;
  logic [CNT_W-1:0]  cnt_inc;
  logic              push;
  logic [ADDR_W-1:0] push_addr;
  logic              f_in_ready;
  logic              f_out_valid;
  logic [WREC_W-1:0] f_out_data;
  logic              drain;
  logic [ADDR_W-1:0] w_addr;
  logic [LANES-1:0]  w_mask;
  logic [DATA_W-1:0] w_data;

  // ************************************************************
  // Input decode
  // ************************************************************

  // Sleep acts on its level at once, not on an edge
  assign asleep_now = sleep_request | (s.wake != 2'h0);          // see R9
  assign cs_on      = ~primary_chip_select_n & second_chip_select & ~third_chip_select_n;
  assign ps_start   = ~processor_address_strobe_n & ~primary_chip_select_n;  // see R8
  assign cs_start   = ~controller_address_strobe_n & ~ps_start;   // see R3
  assign wr_any     = ~global_write_n | (~byte_write_gate_n & ~(&lane_write_n));

  // Per-lane write enables
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    // Global write overrides the gate and lane inputs
    assign lane_mask[g] = ~global_write_n | (~byte_write_gate_n & ~lane_write_n[g]);  // see R6 see R7
  end

  // Burst order: order select is only read as a level, never latched
  assign cnt_inc  = s.cnt + CNT_STEP;
  assign low_cur  = (burst_order_select == ORDER_LIN) ? s.base + s.cnt : s.base ^ s.cnt;    // see R19 see R5
  assign low_next = (burst_order_select == ORDER_LIN) ? s.base + cnt_inc : s.base ^ cnt_inc; // see R19

  assign mem_rd = mem[s.rd_addr];

  // ************************************************************
  // Burst control and read pipeline
  // ************************************************************

  // An unblocked strobe while any select is inactive is a deselect cycle
  assign desel = ~asleep_now & (ps_start | cs_start) & ~cs_on;

  always_comb begin
    next_s    = s;
    push      = 1'b0;
    push_addr = {s.hi, low_cur};
    next_s.rd_p1 = 1'b0;
    next_s.wake  = sleep_request ? WAKE_CYCLES : ((s.wake != 2'h0) ? s.wake - 2'h1 : 2'h0);  // see R16
    next_s.asleep = asleep_now;
    // Address and controls only reach the array through these registers
    if (!asleep_now) begin                                         // see R13 see R15
      if ((ps_start | cs_start) & cs_on) begin
        // New external address; advance is not looked at here
        next_s.active = 1'b1;                                      // see R3 see R17
        next_s.base   = addr[CNT_W-1:0];                           // see R2
        next_s.cnt    = CNT_RESET;
        next_s.hi     = addr[ADDR_W-1:CNT_W];
        if (cs_start & wr_any) begin
          push      = 1'b1;                                        // see R12
          push_addr = addr;
        end else begin
          next_s.rd_p1   = 1'b1;                                   // see R1
          next_s.rd_addr = addr;
        end
      end else if (desel) begin
        next_s.active = 1'b0;
      end else if (s.active) begin
        // Internally generated addresses, stepped by advance
        if (wr_any) begin
          push = 1'b1;                                             // see R4
        end else begin
          next_s.rd_p1   = 1'b1;
          next_s.rd_addr = {s.hi, burst_advance_n ? low_cur : low_next};
        end
        if (!burst_advance_n) begin
          next_s.cnt = cnt_inc;                                    // see R17 see R4
        end
      end
    end
    // Data-out register, then output buffer on the next edge
    next_s.rd_p2 = s.rd_p1;                                        // see R1
    if (s.rd_p1) begin
      next_s.dout = mem_rd;                                        // see R18
    end
    // Deselect drops the drive one edge after it is sampled; selection needs two
    next_s.desel_q = desel;                                        // see R10
    next_s.drive   = s.rd_p2 & ~s.desel_q;                         // see R10
    if (s.rd_p2) begin
      next_s.obuf = s.dout;                                        // see R18
    end
    next_s.wr_ready = f_in_ready;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // Self-timed write path
  // ************************************************************

  // Writes queue here; sleep stalls the drain, and no new writes enter while asleep
  pbs_fifo #(
    .WIDTH (WREC_W),
    .DEPTH (FIFO_D)
  ) u_wfifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   ({push_addr, lane_mask, dq_in}),
    .out_valid (f_out_valid),
    .out_ready (~sleep_request),
    .out_data  (f_out_data)
  );

  assign drain  = f_out_valid & ~sleep_request;                   // see R12
  assign w_addr = f_out_data[WREC_W-1 -: ADDR_W];
  assign w_mask = f_out_data[DATA_W +: LANES];
  assign w_data = f_out_data[DATA_W-1:0];

  // Array update, every masked lane written on the same edge
  always_ff @(posedge mclk) begin
    for (int i = 0; i < LANES; i++) begin
      if (drain & w_mask[i]) begin
        mem[w_addr][i*LANE_W +: LANE_W] <= w_data[i*LANE_W +: LANE_W];
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign dq_out       = s.obuf;
  // Drive enable is combinational on purpose: the output enable pin is not clocked
  assign dq_oe_n      = output_enable_n | ~s.drive;                // see R11
  assign write_ready  = s.wr_ready;
  assign powered_down = s.asleep;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_sleep_end;
    $fell(sleep_request) ##1 !sleep_request;
  endsequence

  sequence s_read_issue;
    s.rd_p1 ##1 (s.rd_p2 && s.dout == $past(mem_rd));
  endsequence

  property p_two_stage;
    s.rd_p1 && $past(s.rd_p1) == 1'b0 |-> s_read_issue;
  endproperty
  a_two_stage: assert property (p_two_stage) else $error("read did not reach data-out stage"); // see R1

  property p_out_capture;
    s.rd_p2 && !s.desel_q |=> s.drive && (s.obuf == $past(s.dout));
  endproperty
  a_out_capture: assert property (p_out_capture) else $error("output buffer missed data-out"); // see R18

  property p_load;
    (ps_start | cs_start) && cs_on && !asleep_now |=> s.active && s.base == $past(addr[1:0]) && s.cnt == 2'h0;
  endproperty
  a_load: assert property (p_load) else $error("burst counter not loaded"); // see R2

  property p_ps_block;
    !processor_address_strobe_n && primary_chip_select_n && controller_address_strobe_n
      && !s.active |=> !s.active;
  endproperty
  a_ps_block: assert property (p_ps_block) else $error("blocked strobe started a burst"); // see R8

  property p_global;
    push && !global_write_n |-> lane_mask == {LANES{1'b1}};
  endproperty
  a_global: assert property (p_global) else $error("global write missed a lane"); // see R6

  property p_lane;
    push && global_write_n |-> lane_mask == ({LANES{~byte_write_gate_n}} & ~lane_write_n);
  endproperty
  a_lane: assert property (p_lane) else $error("lane write mask wrong"); // see R7

  property p_desel;
    desel |-> ##2 !s.drive;
  endproperty
  a_desel: assert property (p_desel) else $error("drivers stayed on after deselect"); // see R10

  property p_wake;
    s_sleep_end |-> asleep_now ##1 (sleep_request || !asleep_now);
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up time not two cycles"); // see R16

  property p_order;
    s.active && burst_order_select != ORDER_LIN && s.cnt == 2'h1 |-> low_cur == {s.base[1], ~s.base[0]};
  endproperty
  a_order: assert property (p_order) else $error("interleaved order wrong"); // see R19

  property p_adv;
    s.active && !asleep_now && !(ps_start | cs_start) && !burst_advance_n |=> s.cnt == $past(s.cnt) + 2'h1;
  endproperty
  a_adv: assert property (p_adv) else $error("advance did not step the burst"); // see R4

endmodule

// >>> pbs_master.sv
// Behavioural processor-side master that starts and advances read bursts and writes single words.
// Assumes callers run its tasks one at a time, timed from the rising edge of mclk.
`timescale 1ns/1ps
// ************************************************************
// Master model
// ************************************************************
module pbs_master (
  input  wire logic [pbs_pkg::DATA_W_WIDE-1:0] dq_out,
  input  wire logic                            mclk,
  input  wire logic                            dq_oe_n,
  output logic      [7:0]                      addr,
  output logic                                 processor_address_strobe_n,
  output logic                                 controller_address_strobe_n,
  output logic                                 burst_advance_n,
  output logic                                 global_write_n,
  output logic                                 byte_write_gate_n,
  output logic      [3:0]                      lane_write_n,
  output logic                                 primary_chip_select_n,
  output logic                                 second_chip_select,
  output logic                                 third_chip_select_n,
  output logic                                 burst_order_select,
  output logic                                 sleep_request,
  output logic                                 output_enable_n,
  output logic      [pbs_pkg::DATA_W_WIDE-1:0] dq_in
);
  import pbs_pkg::*;

  // Idle levels: all selects on, no strobe, no write, linear order
  initial begin
    addr = 8'h00;
    processor_address_strobe_n = 1'b1;
    controller_address_strobe_n = 1'b1;
    burst_advance_n = 1'b1;
    global_write_n = 1'b1;
    byte_write_gate_n = 1'b1;
    lane_write_n = 4'hf;
    primary_chip_select_n = 1'b0;
    second_chip_select = 1'b1;
    third_chip_select_n = 1'b0;
    burst_order_select = 1'b0;
    sleep_request = 1'b0;
    output_enable_n = 1'b0;
    dq_in = 36'h0_0000_0000;
  end

  // One write started by the controller strobe; data rides the same edge
  task automatic write_word(input logic [7:0] a, input logic [35:0] d, input logic gw,
                            input logic gate, input logic [3:0] lanes);
    @(posedge mclk);
    controller_address_strobe_n <= 1'b0;
    addr <= a;
    global_write_n <= gw;
    byte_write_gate_n <= gate;
    lane_write_n <= lanes;
    dq_in <= d;
    @(posedge mclk);
    controller_address_strobe_n <= 1'b1;
    global_write_n <= 1'b1;
    byte_write_gate_n <= 1'b1;
    lane_write_n <= 4'hf;
    dq_in <= ~d; // Released data never repeats the last value
    addr <= ~a;
  endtask

  // Four-beat read; advance is already low on the strobe edge, which must ignore it
  task automatic read_burst(input logic [7:0] a, output logic [35:0] q [4], output logic [3:0] oe);
    @(posedge mclk);
    processor_address_strobe_n <= 1'b0;
    burst_advance_n <= 1'b0;
    addr <= a;
    @(posedge mclk);
    processor_address_strobe_n <= 1'b1;
    addr <= ~a;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      #10;
      q[i] = dq_out;
      oe[i] = dq_oe_n;
      @(posedge mclk);
      if (i == 0) burst_advance_n <= 1'b1; // Three steps after the strobe, then hold
    end
  endtask
endmodule

// >>> pbs_port_test.sv
// Self-checking bench for the burst memory port, with a narrowed address bus.
// Assumes pbs_master drives every synchronous input of the port.
`timescale 1ns/1ps
// ************************************************************
// Bench top
// ************************************************************
module pbs_port_test;
  import pbs_pkg::*;
  logic        mclk;
  logic        rstn;
  logic [7:0]  addr;
  logic        processor_address_strobe_n;
  logic        controller_address_strobe_n;
  logic        burst_advance_n;
  logic        global_write_n;
  logic        byte_write_gate_n;
  logic [3:0]  lane_write_n;
  logic        primary_chip_select_n;
  logic        second_chip_select;
  logic        third_chip_select_n;
  logic        burst_order_select;
  logic        sleep_request;
  logic        output_enable_n;
  logic [35:0] dq_in;
  logic [35:0] dq_out;
  logic        dq_oe_n;
  logic        powered_down;
  logic        write_ready;
  logic [35:0] mem [256];
  logic [35:0] q [4];
  logic [3:0]  oe;
  int          fail_count;
  int          check_count;

  pbs_port #(.ADDR_W(8)) DUT (.mclk, .rstn, .addr, .processor_address_strobe_n,
    .controller_address_strobe_n, .burst_advance_n, .global_write_n, .byte_write_gate_n,
    .lane_write_n, .primary_chip_select_n, .second_chip_select, .third_chip_select_n,
    .burst_order_select, .sleep_request, .output_enable_n, .dq_in, .dq_out, .dq_oe_n,
    .write_ready, .powered_down);

  pbs_master u_master (.mclk, .dq_out, .dq_oe_n, .addr, .processor_address_strobe_n,
    .controller_address_strobe_n, .burst_advance_n, .global_write_n, .byte_write_gate_n,
    .lane_write_n, .primary_chip_select_n, .second_chip_select, .third_chip_select_n,
    .burst_order_select, .sleep_request, .output_enable_n, .dq_in);

  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Data and flag comparisons
  task automatic chk36(input string name, input logic [35:0] e, input logic [35:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chk1(input string name, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", name, e, g);
    end
  endtask

  // Reads one burst and checks each beat in the order the select level picks
  task automatic burst_check(input logic [7:0] a);
    logic [1:0] lo;
    u_master.read_burst(a, q, oe);
    for (int k = 0; k < 4; k++) begin
      lo = burst_order_select ? (a[1:0] ^ k[1:0]) : (a[1:0] + k[1:0]);
      chk36("burst data", mem[{a[7:2], lo}], q[k]);
      chk1("drive enable", 1'b0, oe[k]);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #2000000;
    fail_count++;
    $display("BAD watchdog expected finish seen hang");
    stop_test();
  end

  // Main sequence
  initial begin
    fail_count = 0;
    check_count = 0;
    rstn = 1'b0;
    repeat (6) @(posedge mclk);
    chk1("reset drive enable", 1'b1, dq_oe_n);
    chk1("reset sleep flag", 1'b0, powered_down);
    chk1("reset write ready", 1'b0, write_ready);
    rstn <= 1'b1;
    // Global writes ignore the gate and lane inputs
    for (int i = 0; i < 4; i++) begin
      mem[16 + i] = 36'h9_a5c3_0f00 + 36'(i);
      u_master.write_word(8'(16 + i), mem[16 + i], 1'b0, 1'b1, 4'h0);
    end
    #10 chk1("write ready", 1'b1, write_ready);
    for (int m = 0; m < 2; m++) begin
      u_master.burst_order_select <= m[0];
      repeat (3) @(posedge mclk);
      burst_check(8'h11);
    end
    // Lanes 0 and 2 written; a gate-off attempt writes nothing
    u_master.write_word(8'h12, 36'hf_ffff_ffff, 1'b1, 1'b0, 4'ha);
    mem[8'h12] = mem[8'h12] | 36'h0_07fc_01ff;
    u_master.write_word(8'h13, 36'h0_0000_0000, 1'b1, 1'b1, 4'h0);
    repeat (4) @(posedge mclk);
    burst_check(8'h12);
    // A strobe with the third select off drops the drive after one edge
    u_master.third_chip_select_n <= 1'b1;
    u_master.controller_address_strobe_n <= 1'b0;
    @(posedge mclk);
    u_master.third_chip_select_n <= 1'b0;
    u_master.controller_address_strobe_n <= 1'b1;
    #10 chk1("drive before deselect", 1'b0, dq_oe_n);
    @(posedge mclk);
    #10 chk1("drive after deselect", 1'b1, dq_oe_n);
    // Processor strobe with the primary select off starts nothing
    @(posedge mclk);
    u_master.primary_chip_select_n <= 1'b1;
    u_master.read_burst(8'h10, q, oe);
    for (int k = 0; k < 4; k++) chk1("blocked strobe drive", 1'b1, oe[k]);
    u_master.primary_chip_select_n <= 1'b0;
    // Sleep, wake-up time, then contents still there
    @(posedge mclk);
    u_master.sleep_request <= 1'b1;
    repeat (3) @(posedge mclk);
    #10 chk1("asleep", 1'b1, powered_down);
    @(posedge mclk);
    u_master.sleep_request <= 1'b0;
    @(posedge mclk);
    #10 chk1("waking", 1'b1, powered_down);
    repeat (2) @(posedge mclk);
    #10 chk1("awake", 1'b0, powered_down);
    burst_check(8'h11);
    // Output enable acts within the cycle, not at the next edge
    @(posedge mclk);
    u_master.output_enable_n <= 1'b1;
    #10 chk1("drive off by enable", 1'b1, dq_oe_n);
    stop_test();
  end
endmodule
